// File: jip_defines.svh
// constants for the jtag programming control block
`ifndef JIP_DEFINES_SVH
`define JIP_DEFINES_SVH

// number of user pads under global enable
`define JIP_NPADS      8

// instruction register
`define JIP_IR_W       4
`define JIP_IR_CAPTURE 4'h1
`define JIP_INS_SAMPLE 4'h1
`define JIP_INS_ENTER  4'h8
`define JIP_INS_DATA   4'h9
`define JIP_INS_EXIT   4'ha
`define JIP_INS_BYPASS 4'hf

// programming completion code register
`define JIP_CODE_W     8
`define JIP_DONE_CODE  8'ha5

// system clocks waited before the config strap is taken
`define JIP_STRAP_WAIT 2'h2

`endif

// File: jip_pkg.sv
// types shared by the jtag programming control block
`include "jip_defines.svh"

package jip_pkg;

    typedef enum logic [3:0]
    {
        st_tlr, st_rti,
        st_sel_dr, st_cap_dr, st_sh_dr, st_ex1_dr,
        st_pa_dr, st_ex2_dr, st_upd_dr,
        st_sel_ir, st_cap_ir, st_sh_ir, st_ex1_ir,
        st_pa_ir, st_ex2_ir, st_upd_ir
    } jip_tap_t;

    typedef struct packed
    {
        logic [`JIP_NPADS-1:0] dat;
        logic [`JIP_NPADS-1:0] oe;
    } jip_pad_t;

endpackage

// File: jip_sync.sv
// two flip-flop level synchroniser, any width
module jip_sync
#(
    parameter int W = 1
)
(
    // clock and reset of the receiving domain
    input  wire logic         i_clk,
    input  wire logic         i_rst_b,
    // level from another domain
    input  wire logic [W-1:0] i_d,
    output logic      [W-1:0] o_q
);

    logic [W-1:0] meta_reg;
    logic [W-1:0] meta_next;
    logic [W-1:0] q_next;

    always_comb
    begin
        meta_next = i_d;
        q_next    = meta_reg;
    end

    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            meta_reg <= '0;
            o_q      <= '0;
        end
        else
        begin
            meta_reg <= meta_next;
            o_q      <= q_next;
        end
    end

endmodule

// File: jip_bsr.sv
// boundary scan shift chain, parallel capture of pad states
`include "jip_defines.svh"

module jip_bsr
(
    // test clock and reset
    input  wire logic                  i_tck,
    input  wire logic                  i_trst_b,
    // strobes from the tap
    input  wire logic                  i_capture,
    input  wire logic                  i_shift,
    input  wire logic                  i_tdi,
    // pad states, already synchronised to tck
    input  wire logic [`JIP_NPADS-1:0] i_par,
    output logic                       o_sdo
);

    logic [`JIP_NPADS-1:0] chain_reg;
    logic [`JIP_NPADS-1:0] chain_next;

    always_comb
    begin
        chain_next = chain_reg;
        // [R5] parallel capture
        if (i_capture)
            chain_next = i_par;
        // [R7] shift always runs
        else if (i_shift)
            chain_next = {i_tdi, chain_reg[`JIP_NPADS-1:1]};
    end

    always_ff @(posedge i_tck or negedge i_trst_b)
    begin
        if (!i_trst_b)
            chain_reg <= '0;
        else
            chain_reg <= chain_next;
    end

    assign o_sdo = chain_reg[0];

    AST_BSR_CAPTURE: assert property ( // [R5]
        @(posedge i_tck) disable iff (!i_trst_b)
        i_capture |=> chain_reg == $past(i_par))
        else $error("pad states not captured into scan chain");

    AST_BSR_SHIFT: assert property ( // [R7]
        @(posedge i_tck) disable iff (!i_trst_b)
        (i_shift && !i_capture) |=>
            chain_reg == {$past(i_tdi), $past(chain_reg[`JIP_NPADS-1:1])})
        else $error("scan chain did not shift");

endmodule

// File: jip_prog_ctrl.sv
// jtag tap, in-system programming control and global pad enable
// Operation
// [R1] programming entry refused while the low-power hold mode is active
// [R2] programmer leaves hold mode before sending any jtag instruction
// [R3] unprogrammed part keeps global pad enable off, all pads disabled
// [R4] global pad enable off also blocks pad inputs from the core
// [R5] sample/preload captures all pads in parallel, shifts out on tdo
// [R6] sample/preload never changes pad drive or enable
// [R7] on unprogrammed part sample/preload still shifts; captured data undefined
// [R8] during programming pads tristated and weakly pulled up
// [R9] programmer drives all jtag pins and holds test reset high
// [R10] entry only via tap sequence; pads stay off until programming succeeds
`include "jip_defines.svh"

module jip_prog_ctrl
(
    // system clock and reset
    input  wire logic                  i_clk,
    input  wire logic                  i_rst_b,
    // device state pins
    input  wire logic                  i_hold_mode,
    input  wire logic                  i_cfg_strap,
    // jtag link
    input  wire logic                  i_tck,
    input  wire logic                  i_trst_b,
    input  wire logic                  i_tms,
    input  wire logic                  i_tdi,
    output logic                       o_tdo,
    output logic                       o_tdo_oe,
    // user pads
    input  wire logic [`JIP_NPADS-1:0] i_pad_in,
    output jip_pkg::jip_pad_t          o_pad,
    output logic                       o_pad_en,
    output logic                       o_pad_pullup,
    // core side
    input  wire jip_pkg::jip_pad_t     i_core,
    output logic [`JIP_NPADS-1:0]      o_core_in,
    output logic                       o_programmed,
    output logic                       o_prog_active
);

    // ---------------- tck domain ----------------

    function automatic jip_pkg::jip_tap_t tap_step(
        input jip_pkg::jip_tap_t s,
        input logic              tms
    );
        case (s)
            jip_pkg::st_tlr:    tap_step = tms ? jip_pkg::st_tlr
                                               : jip_pkg::st_rti;
            jip_pkg::st_rti:    tap_step = tms ? jip_pkg::st_sel_dr
                                               : jip_pkg::st_rti;
            jip_pkg::st_sel_dr: tap_step = tms ? jip_pkg::st_sel_ir
                                               : jip_pkg::st_cap_dr;
            jip_pkg::st_cap_dr: tap_step = tms ? jip_pkg::st_ex1_dr
                                               : jip_pkg::st_sh_dr;
            jip_pkg::st_sh_dr:  tap_step = tms ? jip_pkg::st_ex1_dr
                                               : jip_pkg::st_sh_dr;
            jip_pkg::st_ex1_dr: tap_step = tms ? jip_pkg::st_upd_dr
                                               : jip_pkg::st_pa_dr;
            jip_pkg::st_pa_dr:  tap_step = tms ? jip_pkg::st_ex2_dr
                                               : jip_pkg::st_pa_dr;
            jip_pkg::st_ex2_dr: tap_step = tms ? jip_pkg::st_upd_dr
                                               : jip_pkg::st_sh_dr;
            jip_pkg::st_upd_dr: tap_step = tms ? jip_pkg::st_sel_dr
                                               : jip_pkg::st_rti;
            jip_pkg::st_sel_ir: tap_step = tms ? jip_pkg::st_tlr
                                               : jip_pkg::st_cap_ir;
            jip_pkg::st_cap_ir: tap_step = tms ? jip_pkg::st_ex1_ir
                                               : jip_pkg::st_sh_ir;
            jip_pkg::st_sh_ir:  tap_step = tms ? jip_pkg::st_ex1_ir
                                               : jip_pkg::st_sh_ir;
            jip_pkg::st_ex1_ir: tap_step = tms ? jip_pkg::st_upd_ir
                                               : jip_pkg::st_pa_ir;
            jip_pkg::st_pa_ir:  tap_step = tms ? jip_pkg::st_ex2_ir
                                               : jip_pkg::st_pa_ir;
            jip_pkg::st_ex2_ir: tap_step = tms ? jip_pkg::st_upd_ir
                                               : jip_pkg::st_sh_ir;
            jip_pkg::st_upd_ir: tap_step = tms ? jip_pkg::st_sel_dr
                                               : jip_pkg::st_rti;
            default:            tap_step = jip_pkg::st_tlr;
        endcase
    endfunction

    jip_pkg::jip_tap_t       tap_reg;
    jip_pkg::jip_tap_t       tap_next;
    logic [`JIP_IR_W-1:0]    ir_sh_reg;
    logic [`JIP_IR_W-1:0]    ir_sh_next;
    logic [`JIP_IR_W-1:0]    ir_reg;
    logic [`JIP_IR_W-1:0]    ir_next;
    logic                    byp_reg;
    logic                    byp_next;
    logic [`JIP_CODE_W-1:0]  code_sh_reg;
    logic [`JIP_CODE_W-1:0]  code_sh_next;
    logic                    prog_reg;
    logic                    prog_next;
    logic                    ok_reg;
    logic                    ok_next;
    logic                    pass_reg;
    logic                    pass_next;
    logic                    tdo_next;
    logic                    tdo_oe_next;
    logic                    hold_tck;
    logic [`JIP_NPADS-1:0]   pad_tck;
    logic                    bsr_cap;
    logic                    bsr_shift;
    logic                    bsr_sdo;

    jip_sync #(.W(1)) u_hold_sync
    (
        .i_clk   (i_tck),
        .i_rst_b (i_trst_b),
        .i_d     (i_hold_mode),
        .o_q     (hold_tck)
    );

    jip_sync #(.W(`JIP_NPADS)) u_pad_tck_sync
    (
        .i_clk   (i_tck),
        .i_rst_b (i_trst_b),
        .i_d     (i_pad_in),
        .o_q     (pad_tck)
    );

    // capture takes the tck-synchronised pins, so an unprogrammed part
    // still gives the chain something, though nothing meaningful
    assign bsr_cap   = (tap_reg == jip_pkg::st_cap_dr)
                     && (ir_reg == `JIP_INS_SAMPLE);
    assign bsr_shift = (tap_reg == jip_pkg::st_sh_dr)
                     && (ir_reg == `JIP_INS_SAMPLE);

    jip_bsr u_bsr
    (
        .i_tck     (i_tck),
        .i_trst_b  (i_trst_b),
        .i_capture (bsr_cap),
        .i_shift   (bsr_shift),
        .i_tdi     (i_tdi),
        .i_par     (pad_tck),
        .o_sdo     (bsr_sdo)
    );

    always_comb
    begin
        // [R10] standard tap sequence
        tap_next      = tap_step(tap_reg, i_tms);
        ir_sh_next    = ir_sh_reg;
        ir_next       = ir_reg;
        byp_next      = byp_reg;
        code_sh_next  = code_sh_reg;
        prog_next     = prog_reg;
        ok_next       = ok_reg;
        pass_next     = pass_reg;
        case (tap_reg)
            jip_pkg::st_tlr:
            begin
                // an aborted session never counts as success
                ir_next   = `JIP_INS_BYPASS;
                prog_next = 1'b0;
                ok_next   = 1'b0;
            end
            jip_pkg::st_cap_ir:
                ir_sh_next = `JIP_IR_CAPTURE;
            jip_pkg::st_sh_ir:
                ir_sh_next = {i_tdi, ir_sh_reg[`JIP_IR_W-1:1]};
            jip_pkg::st_upd_ir:
            begin
                ir_next = ir_sh_reg;
                // [R1] refuse entry in hold mode
                if (ir_sh_reg == `JIP_INS_ENTER && !hold_tck)
                begin
                    prog_next = 1'b1;
                    ok_next   = 1'b0;
                    pass_next = 1'b0;
                end
                // [R10] success needed for release
                // a level, not a toggle: a tap reset must not look
                // like a completion to the system clock side
                if (ir_sh_reg == `JIP_INS_EXIT && prog_reg)
                begin
                    prog_next = 1'b0;
                    ok_next   = 1'b0;
                    pass_next = ok_reg;
                end
            end
            jip_pkg::st_cap_dr:
            begin
                byp_next     = 1'b0;
                code_sh_next = {{(`JIP_CODE_W-1){1'b0}}, ok_reg};
            end
            jip_pkg::st_sh_dr:
            begin
                byp_next     = i_tdi;
                code_sh_next = {i_tdi, code_sh_reg[`JIP_CODE_W-1:1]};
            end
            jip_pkg::st_upd_dr:
                if (ir_reg == `JIP_INS_DATA && prog_reg)
                    ok_next = (code_sh_reg == `JIP_DONE_CODE);
            default:
                ;
        endcase
    end

    always_ff @(posedge i_tck or negedge i_trst_b)
    begin
        if (!i_trst_b)
        begin
            tap_reg      <= jip_pkg::st_tlr;
            ir_sh_reg    <= '0;
            ir_reg       <= `JIP_INS_BYPASS;
            byp_reg      <= 1'b0;
            code_sh_reg  <= '0;
            prog_reg     <= 1'b0;
            ok_reg       <= 1'b0;
            pass_reg     <= 1'b0;
        end
        else
        begin
            tap_reg      <= tap_next;
            ir_sh_reg    <= ir_sh_next;
            ir_reg       <= ir_next;
            byp_reg      <= byp_next;
            code_sh_reg  <= code_sh_next;
            prog_reg     <= prog_next;
            ok_reg       <= ok_next;
            pass_reg     <= pass_next;
        end
    end

    always_comb
    begin
        tdo_next    = 1'b0;
        tdo_oe_next = 1'b0;
        if (tap_reg == jip_pkg::st_sh_ir)
        begin
            tdo_next    = ir_sh_reg[0];
            tdo_oe_next = 1'b1;
        end
        else if (tap_reg == jip_pkg::st_sh_dr)
        begin
            tdo_oe_next = 1'b1;
            // [R5] scan data out
            if (ir_reg == `JIP_INS_SAMPLE)
                tdo_next = bsr_sdo;
            else if (ir_reg == `JIP_INS_DATA)
                tdo_next = code_sh_reg[0];
            else
                tdo_next = byp_reg;
        end
    end

    // tdo changes on the falling edge so the programmer samples it clean
    always_ff @(negedge i_tck or negedge i_trst_b)
    begin
        if (!i_trst_b)
        begin
            o_tdo    <= 1'b0;
            o_tdo_oe <= 1'b0;
        end
        else
        begin
            o_tdo    <= tdo_next;
            o_tdo_oe <= tdo_oe_next;
        end
    end

    // ---------------- system clock domain ----------------

    logic [1:0]             link_s;
    logic                   strap_s;
    logic [`JIP_NPADS-1:0]  pad_s;
    logic [1:0]             strap_cnt_reg;
    logic [1:0]             strap_cnt_next;
    logic                   programmed_next;
    logic                   pad_en_next;
    logic                   pullup_next;
    logic                   active_next;
    jip_pkg::jip_pad_t      pad_next;
    logic [`JIP_NPADS-1:0]  core_in_next;
    logic                   pass_s;

    jip_sync #(.W(2)) u_link_sync
    (
        .i_clk   (i_clk),
        .i_rst_b (i_rst_b),
        .i_d     ({prog_reg, pass_reg}),
        .o_q     (link_s)
    );

    jip_sync #(.W(1)) u_strap_sync
    (
        .i_clk   (i_clk),
        .i_rst_b (i_rst_b),
        .i_d     (i_cfg_strap),
        .o_q     (strap_s)
    );

    jip_sync #(.W(`JIP_NPADS)) u_pad_sync
    (
        .i_clk   (i_clk),
        .i_rst_b (i_rst_b),
        .i_d     (i_pad_in),
        .o_q     (pad_s)
    );

    assign pass_s = link_s[0];

    always_comb
    begin
        strap_cnt_next  = strap_cnt_reg;
        programmed_next = o_programmed;
        // strap is only valid behind its two sync flops: the last
        // load, on the third edge, is the one that sticks
        if (strap_cnt_reg <= `JIP_STRAP_WAIT)
        begin
            strap_cnt_next  = strap_cnt_reg + 2'h1;
            programmed_next = strap_s;
        end
        // [R10] completion sets, wins over erase
        else if (pass_s)
            programmed_next = 1'b1;
        else if (link_s[1])
            programmed_next = 1'b0;
        // [R3] pads off unless programmed
        pad_en_next  = o_programmed && !link_s[1];
        // [R8] weak pull-up while programming
        pullup_next  = link_s[1];
        active_next  = link_s[1];
        // [R6] pads driven by core only
        pad_next.dat = i_core.dat;
        pad_next.oe  = i_core.oe & {`JIP_NPADS{o_pad_en}};
        // [R4] input buffers gated
        core_in_next = pad_s & {`JIP_NPADS{o_pad_en}};
    end

    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            strap_cnt_reg <= 2'h0;
            o_programmed  <= 1'b0;
            o_pad_en      <= 1'b0;
            o_pad_pullup  <= 1'b0;
            o_prog_active <= 1'b0;
            o_pad         <= '0;
            o_core_in     <= '0;
        end
        else
        begin
            strap_cnt_reg <= strap_cnt_next;
            o_programmed  <= programmed_next;
            o_pad_en      <= pad_en_next;
            o_pad_pullup  <= pullup_next;
            o_prog_active <= active_next;
            o_pad         <= pad_next;
            o_core_in     <= core_in_next;
        end
    end

    // ---------------- checks ----------------

    sequence s_tms_high;
        i_tms [*5];
    endsequence

    AST_TAP_RESET: assert property ( // [R10]
        @(posedge i_tck) disable iff (!i_trst_b)
        s_tms_high |=> tap_reg == jip_pkg::st_tlr)
        else $error("five tms highs did not reach test-logic-reset");

    AST_HOLD_REFUSE: assert property ( // [R1]
        @(posedge i_tck) disable iff (!i_trst_b)
        (tap_reg == jip_pkg::st_upd_ir && ir_sh_reg == `JIP_INS_ENTER
            && hold_tck && !prog_reg) |=> !prog_reg)
        else $error("programming entered during hold mode");

    AST_EXIT_NEEDS_OK: assert property ( // [R10]
        @(posedge i_tck) disable iff (!i_trst_b)
        (tap_reg == jip_pkg::st_upd_ir && ir_sh_reg == `JIP_INS_EXIT
            && !ok_reg) |=> $stable(pass_reg))
        else $error("completion signalled without success code");

    AST_PADEN_UNPROG: assert property ( // [R3]
        @(posedge i_clk) disable iff (!i_rst_b)
        !o_programmed |=> !o_pad_en)
        else $error("pad enable active on unprogrammed part");

    AST_INBUF_GATE: assert property ( // [R4]
        @(posedge i_clk) disable iff (!i_rst_b)
        !o_pad_en |=> o_core_in == '0)
        else $error("pad input reached core with pads disabled");

    AST_PROG_TRISTATE: assert property ( // [R8]
        @(posedge i_clk) disable iff (!i_rst_b)
        (link_s[1] && $past(link_s[1])) |=>
            (o_pad.oe == '0 && o_pad_pullup))
        else $error("pads not tristated and pulled up in programming");

    AST_NO_IO_EFFECT: assert property ( // [R6]
        @(posedge i_clk) disable iff (!i_rst_b)
        o_pad_en ##1 1'b1 |->
            o_pad.oe == $past(i_core.oe))
        else $error("pad enable differs from core request");

endmodule

// File: jip_prog_model.sv
// jtag programmer model: drives the test port, tck runs only inside frames
module jip_prog_model
(
    // jtag pins driven by the programmer
    output logic      o_tck,
    output logic      o_trst_b,
    output logic      o_tms,
    output logic      o_tdi,
    // answer from the device
    input  wire logic i_tdo,
    input  wire logic i_tdo_oe
);
    timeunit 1ns;
    timeprecision 100ps;

    initial
    begin
        o_tck    = 1'b0;
        o_trst_b = 1'b0;
        o_tms    = 1'b1;
        o_tdi    = 1'b1;
    end

    task automatic tick(input logic tms, input logic tdi, output logic tdo);
        o_tms = tms;
        o_tdi = tdi;
        #6;
        // a released tdo reads inverted so it never matches by chance
        tdo = i_tdo_oe ? i_tdo : ~i_tdo;
        o_tck = 1'b1;
        #6;
        o_tck = 1'b0;
    endtask

    // test reset pulsed, then held high for the whole session
    task automatic reset_tap;
        logic t;
        o_trst_b = 1'b0;
        tick(1'b1, 1'b1, t);
        o_trst_b = 1'b1;
        repeat (5) tick(1'b1, 1'b1, t);
        tick(1'b0, 1'b1, t);
    endtask

    // scan from run-test/idle back to run-test/idle, lsb first
    task automatic scan(input logic ir, input int w, input logic [15:0] din,
                        output logic [15:0] dout);
        logic t;
        dout = 16'h0000;
        tick(1'b1, 1'b1, t);
        if (ir)
            tick(1'b1, 1'b1, t);
        tick(1'b0, 1'b1, t);
        tick(1'b0, 1'b1, t);
        for (int i = 0; i < w; i++)
        begin
            tick(i == w - 1, din[i], t);
            dout[i] = t;
        end
        tick(1'b1, 1'b1, t);
        repeat (4) tick(1'b0, 1'b1, t);
    endtask
endmodule

// File: tb.sv
// self-checking bench for the jtag programming control block
`include "jip_defines.svh"

module tb;
    timeunit 1ns;
    timeprecision 100ps;

    logic                  i_clk       = 1'b0;
    logic                  i_rst_b     = 1'b0;
    logic                  i_hold_mode = 1'b0;
    logic                  i_cfg_strap = 1'b0;
    logic                  tck;
    logic                  trst_b;
    logic                  tms;
    logic                  tdi;
    logic                  tdo;
    logic                  tdo_oe;
    logic [`JIP_NPADS-1:0] i_pad_in    = 8'h5a;
    jip_pkg::jip_pad_t     o_pad;
    logic                  o_pad_en;
    logic                  o_pad_pullup;
    jip_pkg::jip_pad_t     i_core      = 16'hc3ff;
    logic [`JIP_NPADS-1:0] o_core_in;
    logic                  o_programmed;
    logic                  o_prog_active;
    int                    errors      = 0;
    int                    comparisons = 0;
    int                    cycles      = 0;
    logic [15:0]           out;

    jip_prog_ctrl i_jip_prog_ctrl
    (
        .i_clk(i_clk), .i_rst_b(i_rst_b), .i_hold_mode(i_hold_mode),
        .i_cfg_strap(i_cfg_strap), .i_tck(tck), .i_trst_b(trst_b),
        .i_tms(tms), .i_tdi(tdi), .o_tdo(tdo), .o_tdo_oe(tdo_oe),
        .i_pad_in(i_pad_in), .o_pad(o_pad), .o_pad_en(o_pad_en),
        .o_pad_pullup(o_pad_pullup), .i_core(i_core),
        .o_core_in(o_core_in), .o_programmed(o_programmed),
        .o_prog_active(o_prog_active)
    );

    jip_prog_model i_jip_prog_model
    (
        .o_tck(tck), .o_trst_b(trst_b), .o_tms(tms), .o_tdi(tdi),
        .i_tdo(tdo), .i_tdo_oe(tdo_oe)
    );

    initial
    begin
        forever #50 i_clk = ~i_clk;
    end

    task automatic complete_run;
        if (errors == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // a hung handshake would otherwise stall the run for ever
    always @(posedge i_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            errors++;
            complete_run();
        end
    end

    task automatic check_bit(input logic got, input logic exp, input string s);
        comparisons++;
        if (got !== exp)
        begin
            errors++;
            $display("CHECK FAILED at %0t: %s", $time, s);
        end
    endtask

    task automatic check_vec(input logic [15:0] got, input logic [15:0] exp,
                             input string s);
        comparisons++;
        if (got !== exp)
        begin
            errors++;
            $display("CHECK FAILED at %0t: %s %h/%h", $time, s, got, exp);
        end
    endtask

    task automatic wait_flag(input bit sel, input logic val);
        int n;
        n = 0;
        while (n < 40 && (sel ? o_programmed : o_prog_active) !== val)
        begin
            @(negedge i_clk);
            n++;
        end
    endtask

    task automatic do_reset(input logic strap);
        @(posedge i_clk);
        i_cfg_strap <= strap;
        i_rst_b     <= 1'b0;
        repeat (2) @(posedge i_clk);
        i_rst_b <= 1'b1;
        i_jip_prog_model.reset_tap();
        repeat (6) @(negedge i_clk);
    endtask

    task automatic check_pads(input logic en);
        check_bit(o_pad_en, en, "pad enable");
        check_vec(o_pad, {8'hc3, en ? 8'hff : 8'h00}, "pad drive");
        check_vec({8'h00, o_core_in}, en ? 16'h005a : 16'h0000,
                  "core in");
    endtask

    task automatic load_ir(input logic [3:0] code);
        i_jip_prog_model.scan(1'b1, 4, {12'h000, code}, out);
        check_vec(out & 16'h000f, 16'h0001, "ir capture");
    endtask

    task automatic s_sample(input logic en);
        load_ir(`JIP_INS_SAMPLE);
        i_jip_prog_model.scan(1'b0, 16, 16'h003c, out);
        if (en)
            check_vec({8'h00, out[7:0]}, 16'h005a, "pad capture");
        check_vec({8'h00, out[15:8]}, 16'h003c, "chain shift");
        @(negedge i_clk);
        check_pads(en);
    endtask

    task automatic s_hold;
        @(posedge i_clk);
        i_hold_mode <= 1'b1;
        @(negedge i_clk);
        load_ir(`JIP_INS_ENTER);
        repeat (20) @(negedge i_clk);
        check_bit(o_prog_active, 1'b0, "entry in hold");
        check_pads(1'b1);
        @(posedge i_clk);
        i_hold_mode <= 1'b0;
        @(negedge i_clk);
        load_ir(`JIP_INS_ENTER);
        wait_flag(1'b0, 1'b1);
        check_bit(o_prog_active, 1'b1, "entry");
        repeat (3) @(negedge i_clk);
        check_bit(o_pad_pullup, 1'b1, "pullup");
        check_vec({8'h00, o_pad.oe}, 16'h0000, "pads tristated");
        check_bit(o_programmed, 1'b0, "programmed during session");
    endtask

    task automatic s_code(input logic [7:0] code, input logic ok);
        load_ir(`JIP_INS_DATA);
        i_jip_prog_model.scan(1'b0, 8, {8'h00, code}, out);
        i_jip_prog_model.scan(1'b0, 8, {8'h00, code}, out);
        check_vec(out, {15'h0000, ok}, "code status");
        load_ir(`JIP_INS_EXIT);
        wait_flag(1'b1, ok);
        repeat (4) @(negedge i_clk);
        check_bit(o_prog_active, 1'b0, "session end");
        check_bit(o_programmed, ok, "programmed");
        check_bit(o_pad_pullup, 1'b0, "pullup off");
        check_pads(ok);
    endtask

    task automatic s_abort;
        load_ir(`JIP_INS_ENTER);
        wait_flag(1'b0, 1'b1);
        i_jip_prog_model.reset_tap();
        wait_flag(1'b0, 1'b0);
        repeat (4) @(negedge i_clk);
        check_bit(o_prog_active, 1'b0, "abort");
        check_bit(o_programmed, 1'b0, "aborted not programmed");
        check_pads(1'b0);
    endtask

    initial
    begin
        do_reset(1'b1);
        check_bit(o_programmed, 1'b1, "strap programmed");
        check_pads(1'b1);
        s_sample(1'b1);
        s_hold();
        s_code(8'h5a, 1'b0);
        load_ir(`JIP_INS_ENTER);
        s_code(`JIP_DONE_CODE, 1'b1);
        s_abort();
        do_reset(1'b0);
        check_bit(o_programmed, 1'b0, "blank part");
        check_pads(1'b0);
        s_sample(1'b0);
        complete_run();
    end
endmodule
